/* File: core/ims_sequencer.sv */
// Input card mode sequencer: control/address words, gate/flag transfer, service request
// ==========================================================
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ims_sequencer
  import ims_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              nrst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Card slot interface
  output var  logic [SLOT_W-1:0] cardSlot,
  output var  logic              cardGate,
  output var  logic              cardArm,
  output var  logic              groupArm,
  output var  logic              outputsDisable,
  input  wire logic              cardTransferFlag,
  input  wire logic              cardFresh,
  input  wire logic [CARD_W-1:0] cardData,
  // Bus service request
  output var  logic              serviceRequest
);

  // ==========================================================
  // Declarations
  ims_state_t          state_reg;
  ims_state_t          state_next;
  logic [CTRL_W-1:0]   ctrlWord_reg;
  logic                srq_reg;
  logic                flagPrev_reg;
  logic                freshPrev_reg;
  logic                seenCtrl_reg;
  logic                flagS;
  logic                freshS;
  logic [CARD_W-1:0]   dataS;
  logic [RET_W-1:0]    retWord;
  logic                busy;
  logic                access;
  logic                wrAccess;
  logic                mapped;
  logic                ctrlWr;
  logic                addrWr;
  logic [GATE_W-1:0]   gateCode;
  logic                timedStart;
  logic                armStart;
  logic                directRead;
  logic                terminate;
  logic                flagFall;
  logic                freshRise;
  logic                transferDone;
  logic                retLoad;
  logic                pollRd;
  logic                srqSet;
  logic                timingOn;
  logic                groupOn;

  // ==========================================================
  // Pin synchronisers
  ims_sync #(.W(2)) u_syncFlags (
    .mclk    (mclk),
    .nrst    (nrst),
    .pinIn   ({cardFresh, cardTransferFlag}),
    .syncOut ({freshS, flagS})
  );

  ims_sync #(.W(CARD_W)) u_syncData (
    .mclk    (mclk),
    .nrst    (nrst),
    .pinIn   (cardData),
    .syncOut (dataS)
  );

  // ==========================================================
  // APB decode; zero-wait slave
  assign pready   = 1'b1;
  assign access   = psel && penable;
  assign wrAccess = access && pwrite;
  assign mapped   = (paddr == OFF_CTRL) || (paddr == OFF_ADDR) || (paddr == OFF_STATUS)
                 || (paddr == OFF_RETDATA) || (paddr == OFF_POLL);
  assign pslverr  = access && !mapped;
  assign busy     = (state_reg != ST_IDLE);
  assign gateCode = pwdata[GATE_LSB +: GATE_W];
  assign pollRd   = access && !pwrite && (paddr == OFF_POLL);

  // busy lockout: control words are dropped while waiting for the flag
  assign ctrlWr   = wrAccess && (paddr == OFF_CTRL) && !busy;
  assign addrWr   = wrAccess && (paddr == OFF_ADDR);
  // mode split: only select, timing and interrupt bits steer input handling
  assign timingOn = ctrlWord_reg[BIT_TIMING];
  assign groupOn  = ctrlWord_reg[BIT_TIMING] && ctrlWord_reg[BIT_INTMODE];

  // gate codes: T starts, X ends; other address words are ignored while busy
  assign timedStart = addrWr && !busy && (gateCode == GATE_T) && timingOn;
  assign armStart   = addrWr && !busy && (gateCode == GATE_T) && !timingOn;
  assign terminate  = addrWr && busy && (gateCode == GATE_X);
  // direct read: no T gate with input select set means data returned at once
  assign directRead = addrWr && !busy && (gateCode != GATE_T)
                   && ctrlWord_reg[BIT_INSEL];

  // Flag and fresh-data edges from the synchronised pins
  assign flagFall     = flagPrev_reg && !flagS;
  assign freshRise    = freshS && !freshPrev_reg;
  assign transferDone = (state_reg == ST_FLAG) && flagFall;
  // read path: any completion loads the addressed card's word
  assign retLoad      = directRead || transferDone || terminate;

  // ==========================================================
  // Control word register
  // reset clears modes
  // sticky mode: held until a different control word arrives
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrlWord_reg <= CTRL_RESET;
    end else if (ctrlWr) begin
      ctrlWord_reg <= pwdata[CTRL_W-1:0];
    end
  end

  // output disable follows system enable bit of each control word; reset leaves it clear (outputs enabled)
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      outputsDisable <= 1'b0;
    end else if (ctrlWr) begin
      outputsDisable <= !pwdata[BIT_SYSOE];
    end
  end

  // group arming while timing and interrupt modes are both on
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      groupArm <= 1'b0;
    end else begin
      groupArm <= groupOn;
    end
  end

  // Helper for the reset assertion: a control word has been seen
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      seenCtrl_reg <= 1'b0;
    end else if (ctrlWr) begin
      seenCtrl_reg <= 1'b1;
    end
  end

  // ==========================================================
  // Slot latch and single-cycle arm strobe for individual arming
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cardSlot <= '0;
    end else if (addrWr && !busy) begin
      cardSlot <= pwdata[SLOT_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cardArm <= 1'b0;
    end else begin
      cardArm <= armStart;
    end
  end

  // ==========================================================
  // Gate/flag sequencer
  // timed transfer: gate until flag rises, complete on its fall
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (timedStart) state_next = ST_GATE;
      end
      ST_GATE: begin
        if (terminate) state_next = ST_IDLE;
        else if (flagS) state_next = ST_FLAG;
      end
      ST_FLAG: begin
        if (terminate || flagFall) state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // terminate: X drops the gate and returns to idle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cardGate <= 1'b0;
    end else begin
      cardGate <= (state_next == ST_GATE);
    end
  end

  // Edge history for flag and fresh-data lines
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      flagPrev_reg  <= 1'b0;
      freshPrev_reg <= 1'b0;
    end else begin
      flagPrev_reg  <= flagS;
      freshPrev_reg <= freshS;
    end
  end

  // ==========================================================
  // Service request
  // control word with timing mode requests service itself
  // trailing flag edge in timing mode requests service
  // fresh-data rise or flag fall in armed group requests service while idle
  // no other source raises the request
  assign srqSet = (ctrlWr && pwdata[BIT_TIMING])
               || (transferDone && timingOn)
               || (groupOn && !busy && (freshRise || flagFall));

  // poll release; a new event in the same cycle wins over the clear
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      srq_reg <= 1'b0;
    end else if (srqSet) begin
      srq_reg <= 1'b1;
    end else if (pollRd) begin
      srq_reg <= 1'b0;
    end
  end

  assign serviceRequest = srq_reg;

  // ==========================================================
  // Return word: octal coding, request digit
  ims_octal_word u_retWord (
    .mclk      (mclk),
    .nrst      (nrst),
    .load      (retLoad),
    .rawData   (dataS),
    .freshData (freshS),
    .retWord   (retWord)
  );

  // ==========================================================
  // Read data, captured in the setup phase so it stands during access
  // poll byte is 64 only when this device asked for service
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        OFF_CTRL:    prdata <= {{(32-CTRL_W){1'b0}}, ctrlWord_reg};
        OFF_ADDR:    prdata <= {{(32-SLOT_W){1'b0}}, cardSlot};
        OFF_STATUS:  prdata <= {28'h0000000, groupArm, cardGate, srq_reg, busy};
        OFF_RETDATA: prdata <= {{(32-RET_W){1'b0}}, retWord};
        OFF_POLL:    prdata <= srq_reg ? POLL_MINE : POLL_OTHER;
        default:     prdata <= '0;
      endcase
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  poll_clear_a: assert property (pollRd && !srqSet |=> !srq_reg)
    else $error("Poll did not release service request");
  poll_byte_a: assert property (psel && !penable && !pwrite && paddr == OFF_POLL && srq_reg
                                |=> prdata == POLL_MINE)
    else $error("Poll byte not 64 while requesting");
  sye_disable_a: assert property (ctrlWr && !pwdata[BIT_SYSOE] |=> outputsDisable)
    else $error("Outputs not disabled after system enable cleared");
  ctrl_srq_a: assert property (ctrlWr && pwdata[BIT_TIMING] |=> srq_reg)
    else $error("Timing control word raised no request");
  gate_start_a: assert property (timedStart |=> cardGate && busy)
    else $error("Gated address word did not start gate");
  flag_done_a: assert property (transferDone && timingOn |=> srq_reg && !busy)
    else $error("Flag trailing edge did not complete transfer");
  busy_hold_a: assert property (busy && wrAccess && paddr == OFF_CTRL
                                |=> $stable(ctrlWord_reg))
    else $error("Control word acted on while waiting for flag");
  term_idle_a: assert property (terminate |=> !busy && !cardGate)
    else $error("Terminate code did not end gate");
  direct_read_a: assert property (directRead |=> !busy
                                  && retWord[3:0] == {1'b0, $past(dataS[2:0])})
    else $error("Direct read did not return card data");
  reset_quiet_a: assert property (!seenCtrl_reg |-> !srq_reg && ctrlWord_reg == CTRL_RESET)
    else $error("Request or mode set before any control word");

  read_cov: cover property (directRead);
  timed_cov: cover property (timedStart ##[1:1000] transferDone);
  poll_cov: cover property (srq_reg && pollRd);
  group_cov: cover property (groupOn && freshRise);

endmodule // ims_sequencer
`default_nettype wire

/* File: core/ims_pkg.sv */
// Package of constants for the input card mode sequencer
package ims_pkg;

  // ==========================================================
  // APB register map
  localparam int          APB_AW       = 8;
  localparam logic [7:0]  OFF_CTRL     = 8'h00;  // Control word (write), mode bits (read)
  localparam logic [7:0]  OFF_ADDR     = 8'h04;  // Address word (write), last slot (read)
  localparam logic [7:0]  OFF_STATUS   = 8'h08;  // Sequencer status (read)
  localparam logic [7:0]  OFF_RETDATA  = 8'h0C;  // Octal return data word (read)
  localparam logic [7:0]  OFF_POLL     = 8'h10;  // Serial poll status byte (read, clears request)

  // ==========================================================
  // Control word fields
  localparam int          CTRL_W       = 5;
  localparam int          BIT_SYSOE    = 0;      // system_output_enable
  localparam int          BIT_INSEL    = 1;      // input_select
  localparam int          BIT_TIMING   = 2;      // timing_mode_enable
  localparam int          BIT_INTMODE  = 3;      // interrupt_mode_enable
  localparam int          BIT_DTE      = 4;      // data_transfer_enable
  localparam logic [4:0]  CTRL_RESET   = 5'h00;

  // ==========================================================
  // Address word fields
  localparam int          SLOT_W       = 4;
  localparam int          GATE_LSB     = 8;
  localparam int          GATE_W       = 2;
  localparam logic [1:0]  GATE_NONE    = 2'h0;
  localparam logic [1:0]  GATE_T       = 2'h1;   // Start timed transfer or arm
  localparam logic [1:0]  GATE_X       = 2'h2;   // Terminate gate

  // ==========================================================
  // Card data and return word
  localparam int          CARD_W       = 12;     // Four octal digits from the card
  localparam int          DIGITS       = 4;
  localparam int          RET_W        = 20;     // Five octal-coded nibbles
  localparam logic [31:0] POLL_MINE    = 32'h0000_0040;  // Status byte 64
  localparam logic [31:0] POLL_OTHER   = 32'h0000_0000;

  // ==========================================================
  // Sequencer states, Gray coded along idle -> gate -> flag
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_GATE = 2'b01,
    ST_FLAG = 2'b11
  } ims_state_t;

endpackage : ims_pkg

/* File: core/ims_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module ims_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         nrst,
  // Pin side and clean side
  input  wire logic [W-1:0] pinIn,
  output var  logic [W-1:0] syncOut
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // ==========================================================
  // Shift chain; first stage feeds only the second
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= pinIn;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Accept a new value only once the last two stages agree
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      syncOut <= '0;
    end else if (s2_reg == s3_reg) begin
      syncOut <= s3_reg;
    end
  end

endmodule // ims_sync
`default_nettype wire

/* File: core/ims_octal_word.sv */
// Octal-coded return word register with interrupt-request digit
`timescale 1ns/1ps
`default_nettype none
module ims_octal_word
  import ims_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              nrst,
  // Load request with raw card value
  input  wire logic              load,
  input  wire logic [CARD_W-1:0] rawData,
  input  wire logic              freshData,
  // Registered return word
  output var  logic [RET_W-1:0]  retWord
);

  logic [RET_W-1:0] coded;

  // Each octal digit sits in its own nibble; the top nibble holds the request digit
  always_comb begin
    coded = '0;
    for (int i = 0; i < DIGITS; i++) begin
      coded[4*i +: 4] = {1'b0, rawData[3*i +: 3]};
    end
    coded[4*DIGITS +: 4] = {3'b000, freshData};
  end

  // Word holds until the next read of a card
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      retWord <= '0;
    end else if (load) begin
      retWord <= coded;
    end
  end

endmodule // ims_octal_word
`default_nettype wire

/* File: tb/ims_card_model.sv */
// Behavioural input card with gate/flag handshake at the far side
`timescale 1ns/1ps
`default_nettype none
module ims_card_model
  import ims_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              nrst,
  // Sequencer side
  input  wire logic              cardGate,
  output var  logic              cardTransferFlag,
  output var  logic              cardFresh,
  output var  logic [CARD_W-1:0] cardData,
  // Bench controls; delay 0 means the card never answers a gate
  input  wire logic [CARD_W-1:0] newData,
  input  wire logic              setData,
  input  wire logic              freshIn,
  input  wire logic              kick,
  input  wire logic [7:0]        delay
);
  logic       active;
  logic       gatePrev;
  logic [8:0] cnt;

  // ==========================================================
  // Transfer cycle: flag rises after delay, data refreshed while flag high
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      active           <= 1'b0;
      gatePrev         <= 1'b0;
      cnt              <= 9'h000;
      cardTransferFlag <= 1'b0;
      cardFresh        <= 1'b0;
      cardData         <= '0;
    end else begin
      gatePrev  <= cardGate;
      cardFresh <= freshIn;
      if (setData) begin
        cardData <= newData;
      end
      if (!active && delay != 8'h00 && ((cardGate && !gatePrev) || kick)) begin
        active <= 1'b1;
        cnt    <= 9'h000;
      end else if (active) begin
        cnt <= cnt + 9'h001;
        if (cnt == {1'b0, delay}) begin
          cardTransferFlag <= 1'b1;
        end
        // Data settles well before the trailing edge of the flag
        if (cnt == {1'b0, delay} + 9'h001) begin
          cardData <= newData;
        end
        if (cnt == {delay, 1'b0}) begin
          cardTransferFlag <= 1'b0;
          active           <= 1'b0;
        end
      end
    end
  end
endmodule // ims_card_model
`default_nettype wire

/* File: tb/input_card_mode_sequencer_tb_top.sv */
// Self-checking bench for the input card mode sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checksDone++; if ((g) !== (e)) begin nMismatch++; $display("[ERR] %s exp %h got %h", nm, (e), (g)); end end
module input_card_mode_sequencer_tb_top
  import ims_pkg::*;
;
  logic              mclk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [APB_AW-1:0] paddr;
  logic [31:0]       pwdata, prdata, rng, eExp, eMsk;
  logic [SLOT_W-1:0] cardSlot;
  logic              cardGate, cardArm, groupArm, outputsDisable, flag, fresh, srq, eErr;
  logic [CARD_W-1:0] cData, newData;
  logic              setData, freshIn, kick;
  logic [7:0]        delay;
  logic [31:0]       qExp[$];
  logic              qErr[$];
  int                nMismatch, checksDone, cyc, armCnt;

  ims_sequencer i_ims_sequencer (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cardSlot(cardSlot), .cardGate(cardGate), .cardArm(cardArm),
    .groupArm(groupArm), .outputsDisable(outputsDisable), .cardTransferFlag(flag),
    .cardFresh(fresh), .cardData(cData), .serviceRequest(srq));
  ims_card_model i_ims_card_model (.mclk(mclk), .nrst(nrst), .cardGate(cardGate),
    .cardTransferFlag(flag), .cardFresh(fresh), .cardData(cData), .newData(newData),
    .setData(setData), .freshIn(freshIn), .kick(kick), .delay(delay));

  // Clock and cycle ceiling; a hang ends the run as a failure
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    armCnt += (cardArm === 1'b1);
    if (cyc == 6000) begin
      nMismatch++;
      tallyAndFinish();
    end
  end

  // ==========================================================
  // Monitor: oldest note is compared when an access completes
  always @(posedge mclk) begin
    if (psel && penable && pready === 1'b1) begin
      // Mask is popped once here; the macro evaluates its operands twice
      eExp = qExp.pop_front();
      eMsk = qExp.pop_front();
      eErr = qErr.pop_front();
      `CHK("prdata", eExp, prdata & eMsk)
      `CHK("pslverr", eErr, pslverr)
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // Four octal digits LS first, interrupt digit in the fifth nibble
  function automatic logic [31:0] oct(input logic [11:0] r, input logic f);
    return {12'h000, 3'h0, f, 1'b0, r[11:9], 1'b0, r[8:6], 1'b0, r[5:3], 1'b0, r[2:0]};
  endfunction

  // ==========================================================
  // APB master: request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic [31:0] m, input logic er);
    qExp.push_back(e & m);
    qExp.push_back(m);
    qErr.push_back(er);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask
  task automatic rdm(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0, e, m, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rdm(a, e, 32'hFFFF_FFFF);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Bounded wait for the request line
  task automatic waitSrq();
    for (int k = 0; k < 400 && srq !== 1'b1; k++) @(negedge mclk);
  endtask
  task automatic setCard(input logic [11:0] d, input logic f);
    @(posedge mclk);
    newData <= d;
    freshIn <= f;
    setData <= 1'b1;
    @(posedge mclk);
    setData <= 1'b0;
    idle(8);
  endtask
  task automatic tallyAndFinish();
    if (nMismatch == 0 && checksDone > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    mclk = 0; nrst = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
    newData = '0; setData = 0; freshIn = 0; kick = 0; delay = 8'h03; rng = 32'd70236;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    idle(1);
    `CHK("srq", 1'b0, srq)
    rd(OFF_CTRL, 32'h0);
    rd(OFF_STATUS, 32'h0);
    // Direct reads; pass 1 sends no control word, pass 2 clears system enable
    for (int i = 0; i < 3; i++) begin
      rng = xs(rng);
      setCard(rng[11:0], rng[12]);
      if (i != 1) wr(OFF_CTRL, (i == 0) ? 32'h3 : 32'h2);
      wr(OFF_ADDR, i * 3 + 2);
      rd(OFF_RETDATA, oct(rng[11:0], rng[12]));
      rd(OFF_ADDR, i * 3 + 2);
      idle(1);
      `CHK("outputsDisable", i == 2, outputsDisable)
    end
    // Timing mode; controller polls before the gated address word
    wr(OFF_CTRL, 32'h7);
    waitSrq();
    `CHK("srq", 1'b1, srq)
    rd(OFF_POLL, POLL_MINE);
    idle(1);
    `CHK("srq", 1'b0, srq)
    rd(OFF_POLL, POLL_OTHER);
    // next gated read only after the previous card completed
    for (int i = 0; i < 2; i++) begin
      rng = xs(rng);
      @(posedge mclk);
      newData <= rng[11:0];
      delay   <= i ? 8'd30 : 8'd3;
      wr(OFF_ADDR, 32'h103 + i);
      rd(OFF_STATUS, 32'h5);
      `CHK("cardGate", 1'b1, cardGate)
      if (i) begin
        wr(OFF_CTRL, 32'h3);
        wr(OFF_ADDR, 32'h9);
        rd(OFF_CTRL, 32'h7);
        `CHK("cardSlot", 4'h4, cardSlot)
      end
      waitSrq();
      `CHK("srq", 1'b1, srq)
      rd(OFF_STATUS, 32'h2);
      rd(OFF_RETDATA, oct(rng[11:0], freshIn));
      rd(OFF_POLL, POLL_MINE);
    end
    wr(OFF_ADDR, 32'h1);
    idle(12);
    `CHK("srq", 1'b0, srq)
    // Gate that is never answered, cleared by terminate code
    @(posedge mclk);
    delay <= 8'h00;
    wr(OFF_ADDR, 32'h106);
    rdm(OFF_STATUS, 32'h1, 32'h1);
    wr(OFF_ADDR, 32'h206);
    rdm(OFF_STATUS, 32'h0, 32'h5);
    idle(1);
    `CHK("cardGate", 1'b0, cardGate)
    rd(OFF_RETDATA, oct(rng[11:0], freshIn));
    wr(OFF_CTRL, 32'h3);
    rd(OFF_CTRL, 32'h3);
    wr(OFF_ADDR, 32'h102);
    idle(2);
    `CHK("armCnt", 1, armCnt)
    // Armed group: fresh data and a finished process both request service
    wr(OFF_CTRL, 32'hF);
    waitSrq();
    rd(OFF_POLL, POLL_MINE);
    `CHK("groupArm", 1'b1, groupArm)
    @(posedge mclk);
    freshIn <= 1'b0;
    delay   <= 8'h03;
    idle(10);
    rdm(OFF_POLL, 32'h0, 32'hFFFF_FFFF);
    @(posedge mclk);
    freshIn <= 1'b1;
    waitSrq();
    rd(OFF_POLL, POLL_MINE);
    @(posedge mclk);
    kick <= 1'b1;
    @(posedge mclk);
    kick <= 1'b0;
    waitSrq();
    rd(OFF_POLL, POLL_MINE);
    wr(OFF_CTRL, 32'h3);
    // Group arm is registered from the mode bits: one edge behind the write
    idle(2);
    `CHK("groupArm", 1'b0, groupArm)
    // Unmapped address answers with an error; status ignores writes
    apb(1'b0, 8'h14, 32'h0, 32'h0, 32'hFFFF_FFFF, 1'b1);
    wr(OFF_STATUS, 32'hF);
    rd(OFF_STATUS, 32'h0);
    tallyAndFinish();
  end
endmodule // input_card_mode_sequencer_tb_top
`default_nettype wire
